// >>> include/tsw_map.svh
// Named figures for the single-wire thermometer link: times in us,
// cycle conversion at the reference clock, command codes, reset values.
// Assumes ref_clk at 125 MHz; included by the package and both ends.
`ifndef TSW_MAP_SVH
`define TSW_MAP_SVH

`define TSW_CLK_MHZ 125
`define TSW_US2CYC(us) ((us) * `TSW_CLK_MHZ)

`define TSW_DEV_RST_DET_US 480
`define TSW_DEV_PD_WAIT_US 30
`define TSW_DEV_PD_LOW_US 120
`define TSW_DEV_SLOT_US 30

`define TSW_MST_RST_LOW_US 490
`define TSW_MST_RST_HIGH_US 480
`define TSW_MST_PD_SAMPLE_US 70
`define TSW_MST_SLOT_US 70
`define TSW_MST_LOW0_US 65
`define TSW_MST_LOW1_US 5
`define TSW_MST_INIT_US 2
`define TSW_MST_RD_SAMPLE_US 12

`define TSW_CMD_WR_HIGH 8'h01
`define TSW_CMD_WR_LOW 8'h02
`define TSW_CMD_WR_CFG 8'h0C
`define TSW_CMD_RD_HIGH 8'hA1
`define TSW_CMD_RD_LOW 8'hA2
`define TSW_CMD_RD_CFG 8'hAC

`define TSW_REG_RESET 8'h00
`define TSW_LAST_BIT 3'h7

`endif

// >>> include/tsw_pkg.sv
// Types shared by both ends of the single-wire thermometer link.
// Assumes tsw_map.svh is on the include path.
`default_nettype none
`include "tsw_map.svh"

package tsw_pkg;

	typedef enum logic [2:0] {
		TSW_DS_IDLE,
		TSW_DS_RST,
		TSW_DS_PD_WAIT,
		TSW_DS_PD_LOW,
		TSW_DS_CMD,
		TSW_DS_WDATA,
		TSW_DS_RDATA
	} tsw_dev_state_e;

	typedef enum logic [1:0] {
		TSW_MS_IDLE,
		TSW_MS_RST_LOW,
		TSW_MS_RST_HIGH,
		TSW_MS_SLOT
	} tsw_mst_state_e;

	typedef enum logic [1:0] {
		TSW_X_NONE,
		TSW_X_WRITE,
		TSW_X_READ
	} tsw_xfer_e;

	function automatic tsw_xfer_e tsw_cmd_kind(input logic [7:0] c);
		tsw_xfer_e k;
		k = TSW_X_NONE;
		if (c == `TSW_CMD_WR_HIGH || c == `TSW_CMD_WR_LOW ||
		    c == `TSW_CMD_WR_CFG)
			k = TSW_X_WRITE;
		else if (c == `TSW_CMD_RD_HIGH || c == `TSW_CMD_RD_LOW ||
		         c == `TSW_CMD_RD_CFG)
			k = TSW_X_READ;
		return k;
	endfunction

endpackage

`default_nettype wire

// >>> include/tsw_if.sv
// Single open-drain line joining master and device ends.
// Assumes a pull-up: the line is low only while an enabled end drives 0.
`timescale 1ns/1ps
`default_nettype none

interface tsw_if;
	logic dev_out;
	logic dev_oe_n;
	logic mst_out;
	logic mst_oe_n;
	logic line;

	assign line = !((!dev_oe_n && !dev_out) || (!mst_oe_n && !mst_out));

	modport dev (output dev_out, output dev_oe_n, input line);
	modport mst (output mst_out, output mst_oe_n, input line);
endinterface // tsw_if

`default_nettype wire

// >>> verilog/tsw_device.sv
// Device end of the single-wire thermometer link: reset detect,
// presence pulse, write/read slots and the trip and config bytes.
// Assumes one master on tsw_if and ref_clk at 125 MHz.
//
// Functional notes
// - Master starts everything except presence pulse.
// - Master holds reset low at least 480us.
// - Wait 15-60us after rise, presence 60-240us.
// - One data bit per slot.
// - Write slots >=60us, >=1us recovery.
// - Master opens write slots with falling edge.
// - Write one released within 15us.
// - Write zero held low whole slot.
// - Device samples write 15-60us after edge.
// - Master issues read slots right after read command.
// - Read slots >=60us, >=1us recovery.
// - Master opens read slot low >=1us.
// - Device drives zero, releases for one.
// - Read bit valid 15us after edge.
// - Master samples read bit before 15us.
// - Master samples late inside 15us window.
// - Reset, presence, command, then data.
// - Write commands carry one stored data byte.
// - Read commands return stored byte.
// - Bytes travel least significant bit first.
// - Line low over 480us means reset.
// - Idle high between bits is harmless.
`timescale 1ns/1ps
`default_nettype none
`include "tsw_map.svh"

module tsw_device #(
	parameter logic [16:0] RST_DET_CYC = 17'(`TSW_US2CYC(`TSW_DEV_RST_DET_US)),
	parameter logic [16:0] PD_LOW_CYC  = 17'(`TSW_US2CYC(`TSW_DEV_PD_LOW_US))
) (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	tsw_if.dev              bus,
	output logic      [7:0] high_trip,
	output logic      [7:0] low_trip,
	output logic      [7:0] status_cfg,
	output logic      [7:0] last_cmd,
	output logic            wr_strobe
);

	localparam logic [16:0] PD_WAIT_CYC =
		17'(`TSW_US2CYC(`TSW_DEV_PD_WAIT_US));
	localparam logic [16:0] SLOT_CYC =
		17'(`TSW_US2CYC(`TSW_DEV_SLOT_US));

	// ====================================================================
	// Line synchroniser
	logic                   line_s1;
	logic                   line_s2;
	logic                   line_d;
	logic                   fall;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
			line_d  <= 1'b1;
		end else begin
			line_s1 <= bus.line;
			line_s2 <= line_s1;
			line_d  <= line_s2;
		end
	end

	assign fall = line_d && !line_s2;

	// ====================================================================
	// Long-low reset detection
	logic            [16:0] low_cnt;
	logic                   rst_det;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_cnt <= 17'h0;
		end else if (line_s2) begin
			low_cnt <= 17'h0;
		end else if (low_cnt != RST_DET_CYC) begin
			low_cnt <= low_cnt + 17'h1;
		end
	end

	// One pulse per long low
	assign rst_det = !line_s2 && (low_cnt == RST_DET_CYC - 17'h1);

	// ====================================================================
	// Link state machine
	tsw_pkg::tsw_dev_state_e state;
	logic            [16:0] cnt;
	logic                   in_slot;
	logic             [2:0] bit_cnt;
	logic             [7:0] shreg;
	logic             [7:0] rx_byte;
	logic             [7:0] rd_value;
	logic                   slot_done;
	logic                   byte_done;
	logic                   drv_n;

	// Incoming bit enters at the top
	assign rx_byte   = {line_s2, shreg[7:1]};
	assign slot_done = in_slot && (cnt == SLOT_CYC - 17'h1) && !rst_det;
	assign byte_done = slot_done && (bit_cnt == `TSW_LAST_BIT);

	always_comb begin
		if (rx_byte == `TSW_CMD_RD_HIGH) begin
			rd_value = high_trip;
		end else if (rx_byte == `TSW_CMD_RD_LOW) begin
			rd_value = low_trip;
		end else begin
			rd_value = status_cfg;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state    <= tsw_pkg::TSW_DS_IDLE;
			cnt      <= 17'h0;
			in_slot  <= 1'b0;
			bit_cnt  <= 3'h0;
			shreg    <= `TSW_REG_RESET;
			last_cmd <= `TSW_REG_RESET;
			drv_n    <= 1'b1;
		end else if (rst_det) begin
			state   <= tsw_pkg::TSW_DS_RST;
			cnt     <= 17'h0;
			in_slot <= 1'b0;
			bit_cnt <= 3'h0;
			drv_n   <= 1'b1;
		end else begin
			case (state)
			tsw_pkg::TSW_DS_RST: begin
				// Rising edge ends the reset pulse
				if (line_s2) begin
					state <= tsw_pkg::TSW_DS_PD_WAIT;
					cnt   <= 17'h0;
				end
			end
			tsw_pkg::TSW_DS_PD_WAIT: begin
				if (cnt == PD_WAIT_CYC - 17'h1) begin
					state <= tsw_pkg::TSW_DS_PD_LOW;
					cnt   <= 17'h0;
					drv_n <= 1'b0;
				end else begin
					cnt <= cnt + 17'h1;
				end
			end
			tsw_pkg::TSW_DS_PD_LOW: begin
				if (cnt == PD_LOW_CYC - 17'h1) begin
					state   <= tsw_pkg::TSW_DS_CMD;
					cnt     <= 17'h0;
					drv_n   <= 1'b1;
					bit_cnt <= 3'h0;
				end else begin
					cnt <= cnt + 17'h1;
				end
			end
			tsw_pkg::TSW_DS_CMD,
			tsw_pkg::TSW_DS_WDATA,
			tsw_pkg::TSW_DS_RDATA: begin
				if (!in_slot) begin
					// Idle high waits forever for the next slot
					if (fall) begin
						in_slot <= 1'b1;
						cnt     <= 17'h0;
						drv_n   <= (state != tsw_pkg::TSW_DS_RDATA) ||
						           shreg[0];
					end
				end else if (!slot_done) begin
					cnt <= cnt + 17'h1;
				end else begin
					// Write sample point and read release point
					in_slot <= 1'b0;
					drv_n   <= 1'b1;
					bit_cnt <= bit_cnt + 3'h1;
					if (state == tsw_pkg::TSW_DS_RDATA) begin
						shreg <= {1'b0, shreg[7:1]};
					end else begin
						shreg <= rx_byte;
					end
					if (byte_done) begin
						case (state)
						tsw_pkg::TSW_DS_CMD: begin
							last_cmd <= rx_byte;
							case (tsw_pkg::tsw_cmd_kind(rx_byte))
							tsw_pkg::TSW_X_WRITE: begin
								state <= tsw_pkg::TSW_DS_WDATA;
							end
							tsw_pkg::TSW_X_READ: begin
								state <= tsw_pkg::TSW_DS_RDATA;
								shreg <= rd_value;
							end
							default: begin
								state <= tsw_pkg::TSW_DS_IDLE;
							end
							endcase
						end
						default: begin
							// One data byte, then a new reset
							state <= tsw_pkg::TSW_DS_IDLE;
						end
						endcase
					end
				end
			end
			default: begin
				// Slots ignored until the next reset
				state <= tsw_pkg::TSW_DS_IDLE;
			end
			endcase
		end
	end

	// ====================================================================
	// Stored bytes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			high_trip  <= `TSW_REG_RESET;
			low_trip   <= `TSW_REG_RESET;
			status_cfg <= `TSW_REG_RESET;
			wr_strobe  <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			if (byte_done && state == tsw_pkg::TSW_DS_WDATA) begin
				wr_strobe <= 1'b1;
				if (last_cmd == `TSW_CMD_WR_HIGH) begin
					high_trip <= rx_byte;
				end else if (last_cmd == `TSW_CMD_WR_LOW) begin
					low_trip <= rx_byte;
				end else begin
					status_cfg <= rx_byte;
				end
			end
		end
	end

	// ====================================================================
	// Open-drain pin
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus.dev_out  <= 1'b0;
			bus.dev_oe_n <= 1'b1;
		end else begin
			bus.dev_out  <= 1'b0;
			bus.dev_oe_n <= drv_n;
		end
	end

endmodule // tsw_device

`default_nettype wire

// >>> verilog/tsw_master.sv
// Master end of the single-wire thermometer link: one transaction per
// start, made of reset, presence check and, only if presence is seen, command byte and, for read and write commands, a data byte.
// Assumes one device on tsw_if and ref_clk at 125 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "tsw_map.svh"

module tsw_master #(
	parameter logic [16:0] RST_LOW_CYC = 17'(`TSW_US2CYC(`TSW_MST_RST_LOW_US)),
	parameter logic [16:0] RST_HIGH_CYC =
		17'(`TSW_US2CYC(`TSW_MST_RST_HIGH_US)),
	parameter logic [16:0] PD_SAMPLE_CYC =
		17'(`TSW_US2CYC(`TSW_MST_PD_SAMPLE_US)),
	parameter logic [16:0] SLOT_CYC    = 17'(`TSW_US2CYC(`TSW_MST_SLOT_US)),
	parameter logic [16:0] LOW0_CYC    = 17'(`TSW_US2CYC(`TSW_MST_LOW0_US))
) (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	tsw_if.mst              bus,
	input  wire logic       start,
	input  wire logic [7:0] cmd,
	input  wire logic [7:0] wdata,
	output logic            busy,
	output logic            done,
	output logic            presence,
	output logic      [7:0] rdata
);

	localparam logic [16:0] LOW1_CYC = 17'(`TSW_US2CYC(`TSW_MST_LOW1_US));
	localparam logic [16:0] INIT_CYC = 17'(`TSW_US2CYC(`TSW_MST_INIT_US));
	localparam logic [16:0] RD_SAMPLE_CYC =
		17'(`TSW_US2CYC(`TSW_MST_RD_SAMPLE_US));

	// ====================================================================
	// Line synchroniser
	logic                   line_s1;
	logic                   line_s2;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
		end else begin
			line_s1 <= bus.line;
			line_s2 <= line_s1;
		end
	end

	// ====================================================================
	// Transaction sequencer
	tsw_pkg::tsw_mst_state_e state;
	tsw_pkg::tsw_xfer_e     kind;
	logic            [16:0] cnt;
	logic            [16:0] low_end;
	logic             [2:0] bit_cnt;
	logic                   data_phase;
	logic                   rd_slot;
	logic             [7:0] shreg;
	logic             [7:0] wdata_q;
	logic             [7:0] rx;
	logic                   drv_n;

	assign rd_slot = data_phase && (kind == tsw_pkg::TSW_X_READ);

	always_comb begin
		if (rd_slot) begin
			low_end = INIT_CYC;
		end else if (shreg[0]) begin
			low_end = LOW1_CYC;
		end else begin
			low_end = LOW0_CYC;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state      <= tsw_pkg::TSW_MS_IDLE;
			kind       <= tsw_pkg::TSW_X_NONE;
			cnt        <= 17'h0;
			bit_cnt    <= 3'h0;
			data_phase <= 1'b0;
			shreg      <= `TSW_REG_RESET;
			wdata_q    <= `TSW_REG_RESET;
			rx         <= `TSW_REG_RESET;
			rdata      <= `TSW_REG_RESET;
			presence   <= 1'b0;
			busy       <= 1'b0;
			done       <= 1'b0;
			drv_n      <= 1'b1;
		end else begin
			done <= 1'b0;
			case (state)
			tsw_pkg::TSW_MS_IDLE: begin
				if (start) begin
					state      <= tsw_pkg::TSW_MS_RST_LOW;
					kind       <= tsw_pkg::tsw_cmd_kind(cmd);
					shreg      <= cmd;
					wdata_q    <= wdata;
					cnt        <= 17'h0;
					bit_cnt    <= 3'h0;
					data_phase <= 1'b0;
					presence   <= 1'b0;
					busy       <= 1'b1;
					drv_n      <= 1'b0;
				end
			end
			tsw_pkg::TSW_MS_RST_LOW: begin
				if (cnt == RST_LOW_CYC - 17'h1) begin
					state <= tsw_pkg::TSW_MS_RST_HIGH;
					cnt   <= 17'h0;
					drv_n <= 1'b1;
				end else begin
					cnt <= cnt + 17'h1;
				end
			end
			tsw_pkg::TSW_MS_RST_HIGH: begin
				cnt <= cnt + 17'h1;
				if (cnt == PD_SAMPLE_CYC - 17'h1) begin
					presence <= !line_s2;
				end
				if (cnt == RST_HIGH_CYC - 17'h1) begin
					cnt <= 17'h0;
					if (presence) begin
						state <= tsw_pkg::TSW_MS_SLOT;
						drv_n <= 1'b0;
					end else begin
						state <= tsw_pkg::TSW_MS_IDLE;
						busy  <= 1'b0;
						done  <= 1'b1;
					end
				end
			end
			tsw_pkg::TSW_MS_SLOT: begin
				cnt <= cnt + 17'h1;
				if (cnt == low_end - 17'h1) begin
					drv_n <= 1'b1;
				end
				if (rd_slot && cnt == RD_SAMPLE_CYC - 17'h1) begin
					rx <= {line_s2, rx[7:1]};
				end
				// Slot length includes the recovery gap
				if (cnt == SLOT_CYC - 17'h1) begin
					cnt     <= 17'h0;
					bit_cnt <= bit_cnt + 3'h1;
					shreg   <= {1'b0, shreg[7:1]};
					drv_n   <= 1'b0;
					if (bit_cnt == `TSW_LAST_BIT) begin
						if (!data_phase && kind != tsw_pkg::TSW_X_NONE) begin
							data_phase <= 1'b1;
							shreg      <= wdata_q;
						end else begin
							state <= tsw_pkg::TSW_MS_IDLE;
							drv_n <= 1'b1;
							busy  <= 1'b0;
							done  <= 1'b1;
							rdata <= rx;
						end
					end
				end
			end
			default: begin
				state <= tsw_pkg::TSW_MS_IDLE;
			end
			endcase
		end
	end

	// ====================================================================
	// Open-drain pin
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus.mst_out  <= 1'b0;
			bus.mst_oe_n <= 1'b1;
		end else begin
			bus.mst_out  <= 1'b0;
			bus.mst_oe_n <= drv_n;
		end
	end

endmodule // tsw_master

`default_nettype wire

// >>> dv/tsw_chk.sv
// Checker for the single-wire link: watches the shared line and enables.
// Assumes one clock, synchronous active-high reset, counts at 125 MHz.
`timescale 1ns/1ps
`default_nettype none

module tsw_chk #(
	parameter logic [16:0] PD_LOW_CYC = 17'h03A98
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic dev_out,
	input wire logic dev_oe_n,
	input wire logic mst_out,
	input wire logic mst_oe_n,
	input wire logic line
);
	logic [16:0] hi_run;
	logic [16:0] dev_run;
	logic [16:0] mst_run;
	logic [16:0] mst_age;
	logic        pd;
	logic        mst_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ==========================================
	// Run lengths and age since master edge
	always_ff @(posedge ref_clk) begin
		if (srst || !line)
			hi_run <= 17'h00000;
		else if (hi_run != 17'h1FFFF)
			hi_run <= hi_run + 17'h00001;
	end
	always_ff @(posedge ref_clk) begin
		dev_run <= (srst || dev_oe_n) ? 17'h00000 : dev_run + 17'h00001;
	end
	always_ff @(posedge ref_clk) begin
		mst_run <= (srst || mst_oe_n) ? 17'h00000 : mst_run + 17'h00001;
	end
	always_ff @(posedge ref_clk) begin
		mst_q <= srst ? 1'b1 : mst_oe_n;
	end
	always_ff @(posedge ref_clk) begin
		if (srst)
			mst_age <= 17'h1FFFF;
		else if (!mst_oe_n && mst_q)
			mst_age <= 17'h00001;
		else if (mst_age != 17'h1FFFF)
			mst_age <= mst_age + 17'h00001;
	end
	// Presence when the device drives with the master idle
	always_ff @(posedge ref_clk) begin
		if (srst)
			pd <= 1'b0;
		else if (!dev_oe_n && dev_run == 17'h00000)
			pd <= mst_oe_n;
	end

	// ==========================================
	// Assertions
	AST_DRIVE_LOW_ONLY: assert property (!dev_out && !mst_out)
		else $error("line driven high");
	AST_RESET_RELEASED: assert property ($fell(srst) |-> dev_oe_n && mst_oe_n)
		else $error("line not released after reset");
	AST_PD_DELAY: assert property ($fell(dev_oe_n) && mst_oe_n |->
		hi_run >= 17'h00753 && hi_run <= 17'h01D4C)
		else $error("presence delay out of range");
	AST_PD_LENGTH: assert property ($rose(dev_oe_n) && pd |->
		dev_run >= PD_LOW_CYC - 17'h2 && dev_run <= PD_LOW_CYC + 17'h2)
		else $error("presence length wrong");
	AST_RD_HOLD: assert property ($rose(dev_oe_n) && !pd |->
		mst_age >= 17'h00753 && mst_age <= 17'h01D4C)
		else $error("read zero released at wrong time");
	AST_RD_START: assert property ($fell(dev_oe_n) && !mst_oe_n |->
		mst_age <= 17'h00008)
		else $error("read zero started late");
	AST_PD_QUIET: assert property (!dev_oe_n && pd && dev_run != 17'h00000
		|-> mst_oe_n)
		else $error("master drives during presence");
	AST_RECOVERY: assert property ($fell(mst_oe_n) |->
		hi_run >= 17'h0007D && dev_oe_n)
		else $error("slot recovery too short");
	AST_MST_LOW_LEN: assert property ($rose(mst_oe_n) |-> mst_run >= 17'h7D
		&& (mst_run <= 17'h00753 || mst_run > 17'h00EAB))
		else $error("master low time ambiguous");
endmodule // tsw_chk

`default_nettype wire

// >>> dv/tb.sv
// Testbench joining master and device ends over one line.
// Assumes the shared package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        ref_clk;
	logic        srst;
	logic        start;
	logic [7:0]  cmd;
	logic [7:0]  wdata;
	logic        busy;
	logic        done;
	logic        presence;
	logic [7:0]  rdata;
	logic [7:0]  high_trip;
	logic [7:0]  low_trip;
	logic [7:0]  status_cfg;
	logic [7:0]  last_cmd;
	logic        wr_strobe;
	logic [15:0] cap;
	logic [15:0] scnt;
	logic        mq;
	int          err_count;
	int          check_count;
	int          cyc;
	int          strobes;

	tsw_if bus_if();
	// Reset detect sits above presence and write-0 lows
	tsw_device #(.RST_DET_CYC(17'h03C8C)) i_tsw_device (
		.ref_clk, .srst, .bus(bus_if), .high_trip, .low_trip, .status_cfg,
		.last_cmd, .wr_strobe);
	tsw_master #(.RST_LOW_CYC(17'h03D54), .RST_HIGH_CYC(17'h04A38),
		.SLOT_CYC(17'h00F3C), .LOW0_CYC(17'h00EB0)) i_tsw_master (
		.ref_clk, .srst, .bus(bus_if), .start, .cmd, .wdata, .busy, .done,
		.presence, .rdata);
	tsw_chk i_tsw_chk (
		.ref_clk, .srst, .dev_out(bus_if.dev_out),
		.dev_oe_n(bus_if.dev_oe_n), .mst_out(bus_if.mst_out),
		.mst_oe_n(bus_if.mst_oe_n), .line(bus_if.line));

	always #4 ref_clk = ~ref_clk;

	// ==========================================
	// Line bit capture 15us after each master edge, first bit lowest
	always @(posedge ref_clk) begin
		mq <= bus_if.mst_oe_n;
		if (!bus_if.mst_oe_n && mq)
			scnt <= 16'h0001;
		else if (scnt != 16'h0000)
			scnt <= scnt + 16'h0001;
		if (scnt == 16'h0753)
			cap <= {bus_if.line, cap[15:1]};
		if (wr_strobe === 1'b1)
			strobes <= strobes + 1;
		cyc <= cyc + 1;
		if (cyc == 210000) begin
			err_count++;
			close_out;
		end
	end

	// ==========================================
	// Shared tasks
	task check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task go(input logic [7:0] c, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		start = 1'b1;
		cmd = c;
		wdata = d;
		@(posedge ref_clk);
		#1;
		start = 1'b0;
	endtask

	task wait_done;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 110000);
		check({15'h0000, done}, 16'h0001);
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task test_write;
		go(8'h01, 8'h28);
		@(posedge ref_clk);
		#1;
		check({15'h0000, busy}, 16'h0001);
		repeat (1000) @(posedge ref_clk);
		#1;
		start = 1'b1;
		cmd = 8'h02;
		wdata = 8'hFF;
		@(posedge ref_clk);
		#1;
		start = 1'b0;
		wait_done;
		check({15'h0000, presence}, 16'h0001);
		check({high_trip, low_trip}, 16'h2800);
		check({8'h00, last_cmd}, 16'h0001);
		check(16'(strobes), 16'h0001);
		check(cap, 16'h2801);
		$display("test write ended");
	endtask

	task test_read;
		repeat (200) @(posedge ref_clk);
		go(8'hA1, 8'h00);
		wait_done;
		check({8'h00, rdata}, 16'h0028);
		check({status_cfg, last_cmd}, 16'h00A1);
		check(cap, 16'h28A1);
		check({15'h0000, presence}, 16'h0001);
		check(16'(strobes), 16'h0001);
		$display("test read ended");
	endtask

	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		start = 1'b0;
		cmd = 8'h00;
		wdata = 8'h00;
		cap = 16'h0000;
		scnt = 16'h0000;
		mq = 1'b1;
		err_count = 0;
		check_count = 0;
		cyc = 0;
		strobes = 0;
		repeat (16) @(posedge ref_clk);
		#1;
		srst = 1'b0;
		repeat (200) @(posedge ref_clk);
		#1;
		check({high_trip, rdata}, 16'h0000);
		check({13'h0000, busy, presence, bus_if.line}, 16'h0001);
		test_write;
		test_read;
		close_out;
	end
endmodule // tb

`default_nettype wire
